/* File: include/cic_pkg.sv */
// constants for the core implementation control register bank
package cic_pkg;
  localparam logic [9:0] CIC_SPR_NUM = 10'h3ff;
  localparam logic [31:0] CIC_RESET_VALUE = 32'h0000_00fc;
  localparam logic [31:0] CIC_WRITE_MASK = 32'h0703_f801;
  localparam int CIC_BIT_PREFIX_OVR = 26;
  localparam int CIC_BIT_DBG_SEL = 25;
  localparam int CIC_BIT_WAIT_EN = 24;
  localparam int CIC_BIT_DCACHE = 17;
  localparam int CIC_BIT_ICACHE = 16;
  localparam int CIC_BIT_NO_CRPAIR = 15;
  localparam int CIC_BIT_NO_BRPAIR = 14;
  localparam int CIC_BIT_NO_CDISP = 13;
  localparam int CIC_BIT_NO_PIPE = 12;
  localparam int CIC_BIT_IMPRECISE = 11;
  localparam int CIC_BIT_CHECKSTOP = 0;
  localparam logic [15:0] CIC_VEC_HIGH_PREFIX = 16'hfff0;
  localparam logic [15:0] CIC_VEC_LOW_PREFIX = 16'h0000;
endpackage : cic_pkg

/* File: verilog/cic_vector.sv */
// exception vector former
`timescale 1ns/1ps
`default_nettype none
module cic_vector import cic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic prefix_override,
  input wire logic vector_high_select,
  input wire logic [15:0] vector_prefix_register,
  input wire logic req,
  input wire logic [15:0] offset,
  output logic [31:0] vector,
  output logic valid
);
  logic [31:0] vector_reg;
  logic [31:0] vector_next;
  logic valid_reg;
  logic valid_next;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    vector_next = vector_reg;
    valid_next = req;
    if (req) begin
      if (prefix_override) begin
        vector_next = {vector_prefix_register, offset};
      end else if (vector_high_select) begin
        vector_next = {CIC_VEC_HIGH_PREFIX, offset};
      end else begin
        vector_next = {CIC_VEC_LOW_PREFIX, offset};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vector_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
    end else if (ce) begin
      vector_reg <= vector_next;
      valid_reg <= valid_next;
    end
  end

  assign vector = vector_reg;
  assign valid = valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  vec_override_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && req && prefix_override) |=>
      (valid && vector == {$past(vector_prefix_register), $past(offset)}))
    else $error("override vector not taken from prefix register");

  vec_select_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && req && !prefix_override) |=>
      (vector[31:16] == ($past(vector_high_select) ? CIC_VEC_HIGH_PREFIX : CIC_VEC_LOW_PREFIX)))
    else $error("vector upper half not chosen by high select");

  vec_offset_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && req) |=> (vector[15:0] == $past(offset)))
    else $error("vector low half is not the offset");
endmodule : cic_vector
`default_nettype wire

/* File: verilog/cic_top.sv */
// core implementation control register bank
`timescale 1ns/1ps
`default_nettype none
module cic_top import cic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [9:0] spr_num,
  input wire logic spr_wr_stb,
  input wire logic [31:0] spr_wr_data,
  input wire logic spr_rd_stb,
  output logic [31:0] spr_rd_data,
  output logic spr_rd_valid,
  input wire logic msr_vector_high_select,
  input wire logic msr_branch_trace_enable,
  input wire logic msr_single_step_enable,
  input wire logic msr_dbg_event_enable,
  input wire logic msr_wait_state,
  input wire logic msr_machine_check_enable,
  input wire logic [15:0] vector_prefix_register,
  input wire logic exc_req,
  input wire logic [15:0] exc_offset,
  output logic [31:0] exc_vector,
  output logic exc_vector_valid,
  input wire logic instruction_address_compare_hit,
  input wire logic mchk_in,
  output logic dcache_en,
  output logic icache_en,
  output logic no_crlogic_pairing,
  output logic no_branch_pairing,
  output logic no_cond_dispatch,
  output logic no_pipelining,
  output logic mchk_imprecise_ok,
  output logic branch_trace_active,
  output logic single_step_active,
  output logic dbg_event_active,
  output logic embedded_dbg_en,
  output logic iac_event,
  output logic wait_state_enter,
  output logic mchk_exception,
  output logic mchk_continue,
  output logic checkstop_frozen
);
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic spr_hit;

  logic [12:0] out_reg;
  logic [12:0] out_next;
  logic mchk_exc_reg;
  logic mchk_exc_next;
  logic mchk_cont_reg;
  logic mchk_cont_next;
  logic frozen_reg;
  logic frozen_next;

  ////////////////////////////////////////////////////////////////////////////////
  // register access
  assign spr_hit = (spr_num == CIC_SPR_NUM);

  always_comb begin
    ctrl_next = ctrl_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    if (spr_wr_stb && spr_hit && !frozen_reg) begin
      ctrl_next = spr_wr_data & CIC_WRITE_MASK;
    end
    if (spr_rd_stb && spr_hit) begin
      rd_data_next = ctrl_reg & CIC_WRITE_MASK;
      rd_valid_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= CIC_RESET_VALUE & CIC_WRITE_MASK;
      rd_data_reg <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign spr_rd_data = rd_data_reg;
  assign spr_rd_valid = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // control outputs
  always_comb begin
    out_next = '0;
    out_next[0] = ctrl_reg[CIC_BIT_DCACHE];
    out_next[1] = ctrl_reg[CIC_BIT_ICACHE];
    out_next[2] = ctrl_reg[CIC_BIT_NO_CRPAIR];
    out_next[3] = ctrl_reg[CIC_BIT_NO_BRPAIR];
    out_next[4] = ctrl_reg[CIC_BIT_NO_CDISP];
    out_next[5] = ctrl_reg[CIC_BIT_NO_PIPE];
    out_next[6] = ctrl_reg[CIC_BIT_IMPRECISE];
    out_next[7] = !ctrl_reg[CIC_BIT_DBG_SEL] && msr_branch_trace_enable;
    out_next[8] = !ctrl_reg[CIC_BIT_DBG_SEL] && msr_single_step_enable;
    out_next[9] = ctrl_reg[CIC_BIT_DBG_SEL] && msr_dbg_event_enable;
    out_next[10] = ctrl_reg[CIC_BIT_DBG_SEL];
    out_next[11] = ctrl_reg[CIC_BIT_DBG_SEL] && msr_dbg_event_enable
                   && instruction_address_compare_hit;
    out_next[12] = ctrl_reg[CIC_BIT_WAIT_EN] && msr_wait_state;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_reg <= '0;
    end else if (ce) begin
      out_reg <= out_next;
    end
  end

  assign dcache_en = out_reg[0];
  assign icache_en = out_reg[1];
  assign no_crlogic_pairing = out_reg[2];
  assign no_branch_pairing = out_reg[3];
  assign no_cond_dispatch = out_reg[4];
  assign no_pipelining = out_reg[5];
  assign mchk_imprecise_ok = out_reg[6];
  assign branch_trace_active = out_reg[7];
  assign single_step_active = out_reg[8];
  assign dbg_event_active = out_reg[9];
  assign embedded_dbg_en = out_reg[10];
  assign iac_event = out_reg[11];
  assign wait_state_enter = out_reg[12];

  ////////////////////////////////////////////////////////////////////////////////
  // machine check handling
  always_comb begin
    mchk_exc_next = 1'b0;
    mchk_cont_next = 1'b0;
    frozen_next = frozen_reg;
    if (mchk_in && !frozen_reg) begin
      if (msr_machine_check_enable) begin
        mchk_exc_next = 1'b1;
      end else if (ctrl_reg[CIC_BIT_CHECKSTOP]) begin
        frozen_next = 1'b1;
      end else begin
        mchk_cont_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mchk_exc_reg <= 1'b0;
      mchk_cont_reg <= 1'b0;
      frozen_reg <= 1'b0;
    end else if (ce) begin
      mchk_exc_reg <= mchk_exc_next;
      mchk_cont_reg <= mchk_cont_next;
      frozen_reg <= frozen_next;
    end
  end

  assign mchk_exception = mchk_exc_reg;
  assign mchk_continue = mchk_cont_reg;
  assign checkstop_frozen = frozen_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // exception vector
  cic_vector u_vector (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .prefix_override(ctrl_reg[CIC_BIT_PREFIX_OVR]),
    .vector_high_select(msr_vector_high_select),
    .vector_prefix_register(vector_prefix_register),
    .req(exc_req),
    .offset(exc_offset),
    .vector(exc_vector),
    .valid(exc_vector_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  ctrl_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && spr_wr_stb && spr_hit && !frozen_reg) |=>
      (ctrl_reg == ($past(spr_wr_data) & CIC_WRITE_MASK)))
    else $error("written value not held in control register");

  reserved_zero_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    spr_rd_valid |-> ((spr_rd_data & ~CIC_WRITE_MASK) == 32'h0000_0000))
    else $error("reserved bits read nonzero");

  read_back_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && spr_rd_stb && spr_hit) |=> (spr_rd_valid && spr_rd_data == $past(ctrl_reg)))
    else $error("read data does not match control register");

  reset_value_a: assert property (
    @(posedge sys_clk)
    $past(rst) |-> (ctrl_reg == (CIC_RESET_VALUE & CIC_WRITE_MASK)))
    else $error("control register not at reset value");

  debug_style_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    dbg_event_active |-> (!branch_trace_active && !single_step_active))
    else $error("both debug styles active together");

  embedded_off_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && !ctrl_reg[CIC_BIT_DBG_SEL]) |=> (!iac_event && !embedded_dbg_en))
    else $error("embedded debug active in trace mode");

  wait_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && !ctrl_reg[CIC_BIT_WAIT_EN]) |=> !wait_state_enter)
    else $error("wait state entered while disabled");

  cache_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce |=> (dcache_en == $past(ctrl_reg[CIC_BIT_DCACHE])
            && icache_en == $past(ctrl_reg[CIC_BIT_ICACHE])))
    else $error("cache enables do not follow control fields");

  opt_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce |=> (no_pipelining == $past(ctrl_reg[CIC_BIT_NO_PIPE])
            && no_cond_dispatch == $past(ctrl_reg[CIC_BIT_NO_CDISP])))
    else $error("optimisation disables do not follow fields");

  mchk_take_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && mchk_in && msr_machine_check_enable && !frozen_reg) |=>
      (mchk_exception && !mchk_continue && !checkstop_frozen))
    else $error("machine check exception not taken");

  checkstop_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && mchk_in && !msr_machine_check_enable && ctrl_reg[CIC_BIT_CHECKSTOP]) |=>
      checkstop_frozen [*3])
    else $error("checkstop did not freeze and hold");

  mchk_continue_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && mchk_in && !msr_machine_check_enable && !ctrl_reg[CIC_BIT_CHECKSTOP]
     && !frozen_reg) |=> (mchk_continue && !mchk_exception && !checkstop_frozen))
    else $error("continue not signalled on masked machine check");

  hold_state_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !ce |=> ($stable(ctrl_reg) && $stable(out_reg) && $stable(frozen_reg)))
    else $error("state changed while clock enable low");

  frozen_sticky_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    checkstop_frozen |=> checkstop_frozen)
    else $error("checkstop freeze released without reset");

  frozen_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    frozen_reg |=> $stable(ctrl_reg))
    else $error("control register written while frozen");

  frozen_quiet_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    checkstop_frozen |-> (!mchk_exception && !mchk_continue))
    else $error("machine check answered while frozen");

  mchk_single_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(mchk_exception && mchk_continue))
    else $error("exception and continue signalled together");

  trace_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && ctrl_reg[CIC_BIT_DBG_SEL]) |=> (!branch_trace_active && !single_step_active))
    else $error("trace or single step active in debug-event style");

  event_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && !ctrl_reg[CIC_BIT_DBG_SEL]) |=> !dbg_event_active)
    else $error("debug event active in trace style");

  imprecise_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce |=> (mchk_imprecise_ok == $past(ctrl_reg[CIC_BIT_IMPRECISE])))
    else $error("imprecise permission does not follow field");

  pair_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce |=> (no_crlogic_pairing == $past(ctrl_reg[CIC_BIT_NO_CRPAIR])
            && no_branch_pairing == $past(ctrl_reg[CIC_BIT_NO_BRPAIR])))
    else $error("pairing disables do not follow fields");

  wait_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && ctrl_reg[CIC_BIT_WAIT_EN]) |=> (wait_state_enter == $past(msr_wait_state)))
    else $error("wait state does not follow machine-state bit");

  read_quiet_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && !(spr_rd_stb && spr_hit)) |=> (!spr_rd_valid && $stable(spr_rd_data)))
    else $error("read answered without an accepted read");
endmodule : cic_top
`default_nettype wire

/* File: dv/cic_top_test.sv */
// self-checking bench for the core implementation control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end
module cic_top_test import cic_pkg::*;;
  logic sys_clk, rst, ce, spr_wr_stb, spr_rd_stb, spr_rd_valid, exc_req, exc_vector_valid;
  logic msr_vector_high_select, msr_branch_trace_enable, msr_single_step_enable;
  logic msr_dbg_event_enable, msr_wait_state, msr_machine_check_enable;
  logic instruction_address_compare_hit, mchk_in, dcache_en, icache_en, no_crlogic_pairing;
  logic no_branch_pairing, no_cond_dispatch, no_pipelining, mchk_imprecise_ok;
  logic branch_trace_active, single_step_active, dbg_event_active, embedded_dbg_en, iac_event;
  logic wait_state_enter, mchk_exception, mchk_continue, checkstop_frozen;
  logic [9:0] spr_num;
  logic [31:0] spr_wr_data, spr_rd_data, exc_vector;
  logic [15:0] vector_prefix_register, exc_offset;
  int failures = 0;
  int checked = 0;
  cic_top cic_top_inst (.sys_clk, .rst, .ce, .spr_num, .spr_wr_stb, .spr_wr_data, .spr_rd_stb,
    .spr_rd_data, .spr_rd_valid, .msr_vector_high_select, .msr_branch_trace_enable,
    .msr_single_step_enable, .msr_dbg_event_enable, .msr_wait_state,
    .msr_machine_check_enable, .vector_prefix_register, .exc_req, .exc_offset, .exc_vector,
    .exc_vector_valid, .instruction_address_compare_hit, .mchk_in, .dcache_en, .icache_en,
    .no_crlogic_pairing, .no_branch_pairing, .no_cond_dispatch, .no_pipelining,
    .mchk_imprecise_ok, .branch_trace_active, .single_step_active, .dbg_event_active,
    .embedded_dbg_en, .iac_event, .wait_state_enter, .mchk_exception, .mchk_continue,
    .checkstop_frozen);
  ////////////////////////////////////////////////////////////////////////////////////////
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic wr_num(input logic [9:0] num, input logic [31:0] d);
    @(posedge sys_clk);
    spr_num <= num;
    spr_wr_data <= d;
    spr_wr_stb <= 1'b1;
    @(posedge sys_clk);
    spr_wr_stb <= 1'b0;
  endtask : wr_num
  task automatic wr(input logic [31:0] d);
    wr_num(10'h3ff, d);
  endtask : wr
  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic rd_chk(input logic [31:0] exp);
    @(posedge sys_clk);
    spr_num <= 10'h3ff;
    spr_rd_stb <= 1'b1;
    @(posedge sys_clk);
    spr_rd_stb <= 1'b0;
    #1;
    `CHK(spr_rd_valid, 1'b1)
    `CHK(spr_rd_data, exp)
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(32'h0000_0000);
    `CHK({dcache_en, icache_en, checkstop_frozen}, 3'h0)
  endtask : t_reset
  task automatic t_fields;
    wr(32'hffff_ffff);
    settle;
    `CHK({dcache_en, icache_en}, 2'b11)
    `CHK({no_crlogic_pairing, no_branch_pairing, no_cond_dispatch, no_pipelining}, 4'hf)
    `CHK(mchk_imprecise_ok, 1'b1)
    rd_chk(CIC_WRITE_MASK);
    wr_num(10'h3fe, 32'h0000_0000);
    rd_chk(CIC_WRITE_MASK);
    wr(32'h0002_a800);
    settle;
    `CHK({dcache_en, icache_en}, 2'b10)
    `CHK({no_crlogic_pairing, no_branch_pairing, no_cond_dispatch, no_pipelining}, 4'ha)
    wr(32'h0000_0000);
    settle;
    `CHK({dcache_en, icache_en, no_crlogic_pairing, no_pipelining}, 4'h0)
    `CHK(mchk_imprecise_ok, 1'b0)
  endtask : t_fields
  task automatic t_vector;
    logic [31:0] ctl [3] = '{32'h0400_0000, 32'h0, 32'h0};
    logic hs [3] = '{1'b1, 1'b1, 1'b0};
    logic [15:0] up [3] = '{16'h5a3c, CIC_VEC_HIGH_PREFIX, 16'h0000};
    logic [15:0] off [3] = '{16'h0700, 16'h0100, 16'hff00};
    for (int i = 0; i < 3; i++) begin
      wr(ctl[i]);
      @(posedge sys_clk);
      msr_vector_high_select <= hs[i];
      vector_prefix_register <= 16'h5a3c;
      exc_offset <= off[i];
      exc_req <= 1'b1;
      @(posedge sys_clk);
      exc_req <= 1'b0;
      #1;
      `CHK(exc_vector_valid, 1'b1)
      `CHK(exc_vector, {up[i], off[i]})
    end
  endtask : t_vector
  task automatic t_debug;
    logic s;
    for (int i = 0; i < 2; i++) begin
      s = (i == 1);
      wr(s ? 32'h0200_0000 : 32'h0);
      @(posedge sys_clk);
      msr_branch_trace_enable <= 1'b1;
      msr_single_step_enable <= 1'b1;
      msr_dbg_event_enable <= 1'b1;
      instruction_address_compare_hit <= 1'b1;
      settle;
      `CHK({branch_trace_active, single_step_active}, {~s, ~s})
      `CHK(dbg_event_active, s)
      `CHK({embedded_dbg_en, iac_event}, {s, s})
    end
  endtask : t_debug
  task automatic t_wait;
    for (int i = 0; i < 2; i++) begin
      wr(i == 1 ? 32'h0100_0000 : 32'h0);
      @(posedge sys_clk);
      msr_wait_state <= 1'b1;
      settle;
      `CHK(wait_state_enter, (i == 1))
    end
  endtask : t_wait
  task automatic t_mchk;
    logic [31:0] ctl [3] = '{32'h1, 32'h0, 32'h1};
    logic me [3] = '{1'b1, 1'b0, 1'b0};
    logic [2:0] res [3] = '{3'b100, 3'b010, 3'b001};
    for (int i = 0; i < 3; i++) begin
      wr(ctl[i]);
      @(posedge sys_clk);
      msr_machine_check_enable <= me[i];
      mchk_in <= 1'b1;
      @(posedge sys_clk);
      mchk_in <= 1'b0;
      #1;
      `CHK({mchk_exception, mchk_continue, checkstop_frozen}, res[i])
    end
    wr(32'h0);
    rd_chk(32'h0000_0001);
    @(posedge sys_clk);
    msr_machine_check_enable <= 1'b1;
    mchk_in <= 1'b1;
    @(posedge sys_clk);
    mchk_in <= 1'b0;
    #1;
    `CHK({mchk_exception, checkstop_frozen}, 2'b01)
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    settle;
    `CHK(checkstop_frozen, 1'b0)
    rd_chk(32'h0000_0000);
  endtask : t_mchk
  task automatic t_hold;
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(32'h0003_0000);
    settle;
    `CHK({dcache_en, icache_en}, 2'b00)
    @(posedge sys_clk);
    ce <= 1'b1;
    rd_chk(32'h0000_0000);
    wr(32'h0003_0000);
    settle;
    `CHK({dcache_en, icache_en}, 2'b11)
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, ce} = 2'b11;
    {spr_wr_stb, spr_rd_stb, exc_req, mchk_in, instruction_address_compare_hit} = 5'h0;
    {msr_vector_high_select, msr_branch_trace_enable, msr_single_step_enable} = 3'h0;
    {msr_dbg_event_enable, msr_wait_state, msr_machine_check_enable} = 3'h0;
    spr_num = 10'h000;
    spr_wr_data = 32'h0000_0000;
    vector_prefix_register = 16'h0000;
    exc_offset = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_fields;
    t_vector;
    t_debug;
    t_wait;
    t_mchk;
    t_hold;
    summarize;
  end
  initial begin
    #200000;
    failures++;
    summarize;
  end
endmodule : cic_top_test
`default_nettype wire
